// *** verilog/crs_pkg.sv ***
// Package: register map, field positions, timing constants and carriers
package crs_pkg;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [8:0]  BYTE_ORDER_ADDR  = 9'h064;
  localparam logic [8:0]  HW_CONFIG_ADDR   = 9'h074;
  localparam logic [8:0]  PWR_MGMT_ADDR    = 9'h084;
  localparam logic [8:0]  RESET_CTRL_ADDR  = 9'h1F8;
  localparam logic [8:0]  XCVR_BASIC_ADDR  = 9'h100;
  localparam logic [8:0]  MODULE_STAT_ADDR = 9'h104;

  // Reset control bits
  localparam int DIGITAL_RST_POS = 0;
  localparam int XCVR_RST_POS    = 1;
  localparam int MAC_RST_POS     = 5;
  // Transceiver basic control bits
  localparam int XCVR_SOFT_POS   = 15;
  localparam int XCVR_PDOWN_POS  = 11;
  // Ready bit in hardware config and power management
  localparam int READY_POS       = 27;
  // Module status register bits
  localparam int EE_BUSY_POS     = 0;
  localparam int CFG_LOADED_POS  = 1;
  localparam int OUT_EN_POS      = 2;

  localparam logic [31:0] BYTE_ORDER_VAL = 32'h87654321;
  localparam logic [31:0] INVALID_VAL    = 32'h00000000;
  localparam logic [15:0] XCVR_BASIC_RST = 16'h3100;
  localparam logic [7:0]  STRAP_RST      = 8'h00;
  localparam logic [15:0] EXEMPT_RST     = 16'h0000;

  // Timing: 10 MHz clock
  localparam int CLK_MHZ        = 10;
  localparam int TUNE_PULSE_NS  = 1000;
  localparam int OUT_DELAY_NS   = 2000;
  localparam int XCVR_HOLD_NS   = 102000;
  localparam int DIG_RST_US     = 760;
  localparam int POR_MS         = 21;
  localparam int EE_BYTE_US     = 91;
  localparam int TUNE_CYC  = (TUNE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int OUTEN_CYC = (OUT_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int XCVR_CYC  = (XCVR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int DIG_CYC   = DIG_RST_US * CLK_MHZ;
  localparam int POR_CYC   = POR_MS * 1000 * CLK_MHZ;
  localparam int EEB_CYC   = EE_BYTE_US * CLK_MHZ;
  localparam logic [15:0] TUNE_CNT  = 16'(TUNE_CYC);
  localparam logic [15:0] OUTEN_CNT = 16'(OUTEN_CYC);
  localparam logic [15:0] XCVR_CNT  = 16'(XCVR_CYC);

  typedef enum logic [5:0] {
    ST_TUNE  = 6'b000001,
    ST_HOLD  = 6'b000010,
    ST_SYNC  = 6'b000100,
    ST_DIG   = 6'b001000,
    ST_LOAD  = 6'b010000,
    ST_READY = 6'b100000
  } crs_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [8:0] adr;
    logic [31:0] dat;
  } crs_wb_req_s;

  typedef struct packed {
    logic global_rst;
    logic digital_rst;
    logic xcvr_rst;
    logic mac_rst;
  } crs_resets_s;

endpackage

// *** verilog/crs_top.sv ***
// Chip reset sequencer with Wishbone register slave
//
// Summary of operation
// - POR or pin low resets whole device
// - Byte order reads invalid until host reset done
// - Ready bit clear in reset, set when done
// - Strap latches transparent in reset, closed after
// - Tuning pulse 1 us, outputs enabled 2 us later
// - Sync reset to clock forming global reset
// - Chip resets latch straps and start EEPROM load
// - Power-on reset about 21 ms plus load
// - Active-low reset pin starts chip reset
// - Pin or digital reset about 760 us plus load
// - Whole-logic bit resets all but transceiver
// - Digital reset restores soft straps, no relatch
// - Reset-exempt bits survive digital reset
// - Module resets: no strap latch, load only on MAC reset
// - Transceiver reset by either bit, self-clearing
// - Transceiver bits clear about 102 us later
// - Soft reset keeps reset-exempt bits
// - Power-down exit resets transceiver, keeps registers
// - MAC reset clears subsystem, reloads address, self-clears
// - MAC reset sets busy, clears loaded
// - MAC reset keeps MAC interrupt and config bits
// - Reset control bits self-clear, writes ignored while set
`timescale 1ns/10ps
module crs_top
  import crs_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC,
  parameter int DIG_CYCLES = DIG_CYC,
  parameter int EEB_CYCLES = EEB_CYC
) (
  // Clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        CLK_EN,
  input  wire logic        POR_N,
  // Pins and external status
  input  wire logic [7:0]  STRAP_IN,
  input  wire logic [7:0]  EE_BYTES,
  input  wire logic        MAC_MATCH_IRQ,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [8:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  // Reset and pad outputs
  output logic             TUNE_N,
  output logic             OUT_EN,
  output logic             GLOBAL_RST,
  output logic             DIGITAL_RST,
  output logic             XCVR_RST,
  output logic             MAC_RST,
  output logic             EE_LOAD,
  output logic             READY,
  output logic [7:0]       STRAP_OUT
);

  ////////////////////////////////////////////////////////////////////
  // Chip-level reset and sequencer
  crs_state_e  st_q, st_d;
  crs_wb_req_s req;
  crs_resets_s rst_q;
  logic        chip_rst;
  logic [1:0]  sync_q;
  logic [15:0] cnt_q;
  logic [31:0] wait_q;
  logic        por_seen_q;
  logic [7:0]  strap_q, soft_q;
  logic [15:0] xcvr_q;
  logic [15:0] xcnt_q;
  logic        xcvr_bit_q, soft_bit_q, mac_bit_q, dig_bit_q;
  logic        ee_busy_q, cfg_loaded_q, mac_irq_q, mac_cfg_q;
  logic        pdown_q;
  logic [31:0] rdata;
  logic        acc, wr, wr_rst, wr_xcvr, wr_cfg;
  logic [31:0] load_time;
  logic        st_done;

  assign chip_rst = !RESETN || !POR_N;
  assign req = '{WB_CYC_I, WB_STB_I, WB_WE_I, WB_SEL_I, WB_ADR_I, WB_DAT_I};
  assign acc = req.cyc && req.stb && !WB_ACK_O;
  assign wr = acc && req.we && READY;
  assign wr_rst = acc && req.we && req.adr == RESET_CTRL_ADDR && req.sel[0];
  assign wr_xcvr = wr && req.adr == XCVR_BASIC_ADDR && req.sel[1];
  assign wr_cfg = wr && req.adr == HW_CONFIG_ADDR;
  assign load_time = 32'(EEB_CYCLES) * {24'h000000, EE_BYTES};
  assign st_done = cnt_q == 16'h0000;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_TUNE:  if (st_done) st_d = ST_HOLD;
      ST_HOLD:  if (st_done) st_d = ST_SYNC;
      ST_SYNC:  if (sync_q[1]) st_d = ST_DIG;
      ST_DIG:   if (wait_q == 32'h00000000) st_d = ST_LOAD;
      ST_LOAD:  if (wait_q == 32'h00000000) st_d = ST_READY;
      ST_READY: if (dig_bit_q) st_d = ST_DIG;
      default:  st_d = ST_TUNE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge MCLK) begin
    if (chip_rst) begin
      st_q       <= ST_TUNE;
      cnt_q      <= TUNE_CNT - 16'h0001;
      sync_q     <= 2'b00;
      wait_q     <= 32'h00000000;
      por_seen_q <= !POR_N;
    end else if (CLK_EN) begin
      st_q   <= st_d;
      sync_q <= {sync_q[0], st_q == ST_SYNC};
      if (st_q == ST_TUNE && st_done)
        cnt_q <= OUTEN_CNT - 16'h0001;
      else if (!st_done)
        cnt_q <= cnt_q - 16'h0001;
      if (st_q == ST_SYNC && sync_q[1])
        wait_q <= por_seen_q ? 32'(POR_CYCLES) : 32'(DIG_CYCLES);
      else if (st_q == ST_READY && dig_bit_q)
        wait_q <= 32'(DIG_CYCLES);
      else if (st_q == ST_DIG && wait_q == 32'h00000000)
        wait_q <= load_time;
      else if (wait_q != 32'h00000000)
        wait_q <= wait_q - 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Straps and outputs
  always_ff @(posedge MCLK) begin
    if (CLK_EN) begin
      if (chip_rst) begin
        strap_q <= STRAP_IN;
        soft_q  <= STRAP_IN;
      end else if (st_q == ST_DIG) begin
        soft_q  <= strap_q;
      end else if (wr_cfg) begin
        soft_q  <= req.dat[8:1];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (chip_rst) begin
      TUNE_N      <= 1'b1;
      OUT_EN      <= 1'b0;
      GLOBAL_RST  <= 1'b1;
      DIGITAL_RST <= 1'b1;
      EE_LOAD     <= 1'b0;
      READY       <= 1'b0;
      STRAP_OUT   <= STRAP_IN;
    end else if (CLK_EN) begin
      TUNE_N      <= st_q != ST_TUNE;
      OUT_EN      <= st_q != ST_TUNE && st_q != ST_HOLD;
      GLOBAL_RST  <= st_q == ST_TUNE || st_q == ST_HOLD || st_q == ST_SYNC;
      DIGITAL_RST <= st_q != ST_READY && st_q != ST_LOAD;
      EE_LOAD     <= st_q == ST_LOAD || mac_bit_q;
      READY       <= st_q == ST_READY && !dig_bit_q;
      STRAP_OUT   <= soft_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reset control and transceiver control
  always_ff @(posedge MCLK) begin
    if (chip_rst) begin
      dig_bit_q  <= 1'b0;
      xcvr_bit_q <= 1'b0;
      soft_bit_q <= 1'b0;
      mac_bit_q  <= 1'b0;
      xcnt_q     <= 16'h0000;
      xcvr_q     <= XCVR_BASIC_RST;
      pdown_q    <= 1'b0;
      XCVR_RST   <= 1'b1;
    end else if (CLK_EN) begin
      if (st_q == ST_LOAD && wait_q == 32'h00000000)
        dig_bit_q <= 1'b0;
      else if (wr_rst && !dig_bit_q && req.dat[DIGITAL_RST_POS] && READY)
        dig_bit_q <= 1'b1;
      if (wr_rst && READY && !xcvr_bit_q && req.dat[XCVR_RST_POS]) begin
        xcvr_bit_q <= 1'b1;
        xcnt_q     <= XCVR_CNT;
      end else if (wr_xcvr && !soft_bit_q && req.dat[XCVR_SOFT_POS]) begin
        soft_bit_q <= 1'b1;
        xcnt_q     <= XCVR_CNT;
      end else if (xcnt_q != 16'h0000) begin
        xcnt_q <= xcnt_q - 16'h0001;
      end else begin
        xcvr_bit_q <= 1'b0;
        soft_bit_q <= 1'b0;
      end
      if (xcnt_q == 16'h0000 && xcvr_bit_q)
        xcvr_q <= XCVR_BASIC_RST;
      else if (wr_xcvr)
        xcvr_q <= req.dat[15:0] & ~(16'h0001 << XCVR_SOFT_POS);
      pdown_q  <= xcvr_q[XCVR_PDOWN_POS];
      XCVR_RST <= (xcnt_q != 16'h0000) || (pdown_q && !xcvr_q[XCVR_PDOWN_POS]);
      if (wr_rst && READY && !mac_bit_q && req.dat[MAC_RST_POS])
        mac_bit_q <= 1'b1;
      else if (mac_bit_q && !ee_busy_q)
        mac_bit_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // MAC subsystem side effects
  always_ff @(posedge MCLK) begin
    if (chip_rst) begin
      ee_busy_q    <= 1'b0;
      cfg_loaded_q <= 1'b0;
      mac_irq_q    <= 1'b0;
      mac_cfg_q    <= 1'b0;
      MAC_RST      <= 1'b1;
    end else if (CLK_EN) begin
      MAC_RST <= DIGITAL_RST || mac_bit_q;
      if (wr_rst && READY && !mac_bit_q && req.dat[MAC_RST_POS]) begin
        ee_busy_q    <= 1'b1;
        cfg_loaded_q <= 1'b0;
      end else if (ee_busy_q) begin
        ee_busy_q    <= 1'b0;
        cfg_loaded_q <= 1'b1;
      end else if (st_q == ST_LOAD && wait_q == 32'h00000000) begin
        cfg_loaded_q <= 1'b1;
      end
      if (MAC_MATCH_IRQ)
        mac_irq_q <= 1'b1;
      else if (wr && req.adr == MODULE_STAT_ADDR && req.dat[3])
        mac_irq_q <= 1'b0;
      if (wr && req.adr == HW_CONFIG_ADDR)
        mac_cfg_q <= req.dat[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wishbone read mux and ack
  always_comb begin
    rdata = 32'h00000000;
    unique case (req.adr)
      BYTE_ORDER_ADDR:  rdata = DIGITAL_RST ? INVALID_VAL : BYTE_ORDER_VAL;
      HW_CONFIG_ADDR:   rdata = {4'h0, READY, 18'h00000, soft_q, mac_cfg_q};
      PWR_MGMT_ADDR:    rdata = {4'h0, READY, 27'h0000000};
      RESET_CTRL_ADDR:  rdata = {26'h0000000, mac_bit_q, 3'h0, xcvr_bit_q | soft_bit_q, dig_bit_q};
      XCVR_BASIC_ADDR:  rdata = {16'h0000, xcvr_q | ({15'h0000, soft_bit_q} << XCVR_SOFT_POS)};
      MODULE_STAT_ADDR: rdata = {28'h0000000, mac_irq_q, OUT_EN, cfg_loaded_q, ee_busy_q};
      default:          rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (chip_rst) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else if (CLK_EN) begin
      WB_ACK_O <= acc;
      WB_DAT_O <= acc ? rdata : 32'h00000000;
    end
  end

endmodule

// *** dv/crs_monitor.sv ***
// Checker on the chip reset sequencer ports
`timescale 1ns/10ps
module crs_monitor
  import crs_pkg::*;
(
  // Clock and resets
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        POR_N,
  input wire logic [7:0]  STRAP_IN,
  // Wishbone
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [8:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // Sequencer outputs
  input wire logic        TUNE_N,
  input wire logic        OUT_EN,
  input wire logic        GLOBAL_RST,
  input wire logic        DIGITAL_RST,
  input wire logic        READY,
  input wire logic [7:0]  STRAP_OUT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire dig_wr = take && WB_WE_I && WB_ADR_I == RESET_CTRL_ADDR && WB_SEL_I[0] && WB_DAT_I[0];
  ////////////////////////////////////////////////////////////////
  a_por_resets_all: assert property (!POR_N |=> !READY && TUNE_N && !OUT_EN && GLOBAL_RST)
    else $error("outputs not in reset under power-on reset");
  a_strap_transparent: assert property (!POR_N |=> STRAP_OUT == $past(STRAP_IN))
    else $error("straps not following pins in reset");
  a_tune_pulse_len: assert property ($fell(TUNE_N) |-> !TUNE_N[*8] ##1 !TUNE_N ##[1:2] TUNE_N)
    else $error("tuning pulse length wrong");
  a_outen_hold_delay: assert property ($rose(TUNE_N) |-> !OUT_EN[*8] ##[11:14] $rose(OUT_EN))
    else $error("outputs enabled at wrong time");
  a_global_after_out: assert property ($rose(OUT_EN) |-> GLOBAL_RST ##[1:4] !GLOBAL_RST)
    else $error("global reset not released after outputs");
  a_ready_when_done: assert property (READY |-> !GLOBAL_RST && !DIGITAL_RST && OUT_EN)
    else $error("ready while still in reset");
  a_ack_single: assert property (take |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus answer missing or too long");
  a_byte_order_val: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == BYTE_ORDER_ADDR
    |-> WB_DAT_O == ($past(DIGITAL_RST) ? INVALID_VAL : BYTE_ORDER_VAL))
    else $error("byte order read wrong");
  a_digital_start: assert property (dig_wr && READY |-> ##[1:3] DIGITAL_RST && !READY)
    else $error("digital reset not started");
  c_ready: cover property ($rose(READY));
  c_write: cover property (take && WB_WE_I);
  c_digital: cover property (dig_wr && READY);
endmodule
bind crs_top crs_monitor i_crs_monitor (.MCLK, .RESETN, .POR_N, .STRAP_IN, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .WB_SEL_I, .WB_ADR_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .TUNE_N, .OUT_EN,
  .GLOBAL_RST, .DIGITAL_RST, .READY, .STRAP_OUT);

// *** dv/crs_host_model.sv ***
// Host model: classic Wishbone master polling the sequencer
`timescale 1ns/10ps
module crs_host_model
  import crs_pkg::*;
(
  // Bus answer
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  input  wire logic        rdy,
  // Request and hang flag
  output crs_wb_req_s      req,
  output logic             hang
);
  initial begin
    req = '0;
    hang = 1'b0;
  end
  task automatic xfer(input logic we, input logic [8:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    q = '0;
    if (we && !rdy) return;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: s, adr: a, dat: d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) hang <= 1'b1;
    q = rdat;
    req <= '0;
    @(posedge clk);
  endtask
endmodule

// *** dv/crs_top_tb.sv ***
// Testbench for the chip reset sequencer
`timescale 1ns/10ps
module crs_top_tb
  import crs_pkg::*;
;
  localparam int PORC = 50;
  localparam int DIGC = 20;
  localparam int EEBC = 3;
  localparam int FRZ  = 20;
  localparam int BASE = TUNE_CYC + OUTEN_CYC + 2 * EEBC;
  typedef struct {logic [8:0] a; logic [31:0] m; logic [31:0] e;} crs_row_s;
  crs_row_s rows[6] = '{
    '{BYTE_ORDER_ADDR, 32'hFFFFFFFF, BYTE_ORDER_VAL},
    '{HW_CONFIG_ADDR, 32'h08000000, 32'h08000000},
    '{PWR_MGMT_ADDR, 32'h08000000, 32'h08000000},
    '{RESET_CTRL_ADDR, 32'h00000023, 32'h00000000},
    '{MODULE_STAT_ADDR, 32'h00000007, 32'h00000006},
    '{9'h1F0, 32'hFFFFFFFF, 32'h00000000}};
  logic mclk, resetn, por_n, irq, ack, tune_n, out_en, glob, dig, xr, mr, eel, rdy, hang, clk_en;
  logic [7:0] strap_in, strap_o;
  logic [31:0] rdat, q;
  crs_wb_req_s req;
  int n_errors = 0, check_count = 0, cyc_n = 0, xr_cnt = 0, mr_cnt = 0, ee_cnt = 0;
  int a, m, e, t0;
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc_n++;
    if (xr === 1'b1) xr_cnt++;
    if (mr === 1'b1) mr_cnt++;
    if (eel === 1'b1) ee_cnt++;
    if (hang === 1'b1) begin
      n_errors++;
      end_of_test;
    end
  end
  crs_top #(.POR_CYCLES(PORC), .DIG_CYCLES(DIGC), .EEB_CYCLES(EEBC)) i_crs_top (
    .MCLK(mclk), .RESETN(resetn), .CLK_EN(clk_en), .POR_N(por_n), .STRAP_IN(strap_in),
    .EE_BYTES(8'h02), .MAC_MATCH_IRQ(irq), .WB_CYC_I(req.cyc), .WB_STB_I(req.stb),
    .WB_WE_I(req.we), .WB_SEL_I(req.sel), .WB_ADR_I(req.adr), .WB_DAT_I(req.dat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .TUNE_N(tune_n), .OUT_EN(out_en), .GLOBAL_RST(glob),
    .DIGITAL_RST(dig), .XCVR_RST(xr), .MAC_RST(mr), .EE_LOAD(eel), .READY(rdy), .STRAP_OUT(strap_o));
  crs_host_model i_crs_host_model (.clk(mclk), .ack(ack), .rdat(rdat), .rdy(rdy), .req(req), .hang(hang));
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic rw(input logic we, input logic [8:0] ad, input logic [3:0] s, input logic [31:0] d);
    i_crs_host_model.xfer(we, ad, s, d, q);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (rdy !== 1'b1) begin
      n_errors++;
      end_of_test;
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0; resetn = 1'b0; por_n = 1'b1; irq = 1'b0; strap_in = 8'hA5;
    clk_en = 1'b1;
    repeat (16) @(posedge mclk);
    chk(rdy === 1'b0 && glob === 1'b1 && strap_o === 8'hA5, "state in reset");
    resetn <= 1'b1;
    t0 = cyc_n;
    rw(0, BYTE_ORDER_ADDR, 4'hF, 0);
    chk(q === INVALID_VAL, "byte order before ready");
    rw(0, HW_CONFIG_ADDR, 4'hF, 0);
    chk(q[READY_POS] === 1'b0, "ready bit early");
    wait_rdy();
    chk(cyc_n - t0 >= BASE + DIGC && cyc_n - t0 <= BASE + DIGC + 8, "pin reset time");
    strap_in <= 8'h3C;
    repeat (3) @(posedge mclk);
    chk(strap_o === 8'hA5, "straps not held");
    foreach (rows[i]) begin
      rw(0, rows[i].a, 4'hF, 0);
      chk((q & rows[i].m) === rows[i].e, "register read");
    end
    rw(1, HW_CONFIG_ADDR, 4'h3, 32'h000001FF);
    chk(strap_o === 8'hFF, "soft strap write");
    a = xr_cnt; e = ee_cnt;
    rw(1, RESET_CTRL_ADDR, 4'h1, 32'h1);
    t0 = cyc_n;
    rw(0, RESET_CTRL_ADDR, 4'hF, 0);
    chk(q[DIGITAL_RST_POS] === 1'b1 && rdy === 1'b0, "digital reset bit");
    rw(0, BYTE_ORDER_ADDR, 4'hF, 0);
    chk(q === INVALID_VAL, "byte order in digital reset");
    wait_rdy();
    chk(xr_cnt == a && ee_cnt > e && strap_o === 8'hA5, "digital reset effect");
    chk(cyc_n - t0 <= DIGC + 2 * EEBC + 10, "digital reset time");
    rw(0, HW_CONFIG_ADDR, 4'hF, 0);
    chk(q[0] === 1'b1 && q[8:1] === 8'hA5, "exempt bit or soft straps");
    rw(0, RESET_CTRL_ADDR, 4'hF, 0);
    chk(q[DIGITAL_RST_POS] === 1'b0, "digital bit not cleared");
    for (int i = 0; i < 2; i++) begin
      a = xr_cnt;
      rw(1, i ? XCVR_BASIC_ADDR : RESET_CTRL_ADDR, i ? 4'h2 : 4'h1, i ? 32'h8000 : 32'h2);
      repeat (XCVR_CYC + 20) @(posedge mclk);
      chk(xr_cnt - a >= XCVR_CYC - 2 && xr_cnt - a <= XCVR_CYC + 4, "transceiver hold");
      chk(rdy === 1'b1 && dig === 1'b0, "transceiver reset spread");
      rw(0, i ? XCVR_BASIC_ADDR : RESET_CTRL_ADDR, 4'hF, 0);
      chk(q[i ? XCVR_SOFT_POS : XCVR_RST_POS] === 1'b0, "transceiver bit stuck");
    end
    rw(1, XCVR_BASIC_ADDR, 4'h2, 32'h0800);
    a = xr_cnt;
    rw(1, XCVR_BASIC_ADDR, 4'h2, 32'h0000);
    repeat (4) @(posedge mclk);
    chk(xr_cnt - a >= 1 && xr_cnt - a <= 2, "power-down exit reset");
    irq <= 1'b1;
    @(posedge mclk);
    irq <= 1'b0;
    a = xr_cnt; m = mr_cnt; e = ee_cnt;
    rw(1, RESET_CTRL_ADDR, 4'h1, 32'h20);
    repeat (20) @(posedge mclk);
    chk(mr_cnt > m && ee_cnt > e && xr_cnt == a && rdy === 1'b1, "mac reset effect");
    rw(0, RESET_CTRL_ADDR, 4'hF, 0);
    chk(q[MAC_RST_POS] === 1'b0, "mac bit not cleared");
    rw(0, MODULE_STAT_ADDR, 4'hF, 0);
    chk(q[3] === 1'b1, "mac interrupt lost");
    por_n <= 1'b0;
    repeat (4) @(posedge mclk);
    por_n <= 1'b1;
    clk_en <= 1'b0;
    t0 = cyc_n;
    repeat (5) @(posedge mclk);
    chk(tune_n === 1'b1, "state moved while frozen");
    repeat (FRZ - 5) @(posedge mclk);
    clk_en <= 1'b1;
    wait_rdy();
    chk(cyc_n - t0 >= BASE + PORC + FRZ && cyc_n - t0 <= BASE + PORC + FRZ + 8, "power-on time");
    chk(strap_o === 8'h3C, "straps not relatched");
    end_of_test;
  end
endmodule
